//--- core/fwc_flash_ctrl.sv
// command interpreter for write control, suspend and deep sleep
// assumes spi mode 0: sclk and data in are async pins, sampled by clk
`timescale 1ns/100ps
module fwc_flash_ctrl import fwc_pkg::*; #(
   parameter int SUSPEND_CYC = SUSPEND_LATENCY_CYC,
   parameter int RESUME_GAP = RESUME_GAP_CYC,
   parameter int SLEEP_CYC = SLEEP_ENTRY_DELAY_CYC,
   parameter int WAKE_CYC = WAKE_DELAY_CYC,
   parameter int PROG_CYC = PAGE_PROGRAM_CYC,
   parameter int SECTOR_CYC = SECTOR_ERASE_CYC,
   parameter int BLOCK_CYC = BLOCK_ERASE_CYC,
   parameter int CHIP_CYC = 32'(CHIP_ERASE_CYC),
   parameter int REGW_CYC = REG_WRITE_CYC
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sel_n,
   input wire logic sclk,
   input wire logic sdi,
   output logic [7:0] rd_data,
   output logic rd_valid,
   output fwc_regs_t regs,
   output fwc_array_req_t array_req,
   output logic sleeping,
   output logic accept_ready
);
   typedef enum {S_IDLE, S_BUSY, S_SUSP_WAIT, S_SUSPENDED, S_SLEEP_WAIT, S_SLEEP, S_WAKE_WAIT} fwc_state_t;
   fwc_state_t state;
   logic [2:0] sel_sync, sclk_sync, sdi_sync;
   logic sel_q, sclk_q, sdi_q, sclk_d;
   logic [7:0] shift;
   logic [3:0] bit_cnt;
   logic [7:0] opcode;
   logic op_valid, data_phase, op_extra;
   logic [7:0] wdata;
   logic [7:0] status, func;
   fwc_op_t active_op;
   logic [31:0] op_left, timer, gap_cnt;
   function automatic logic is_susp_ok(input logic [7:0] op);
      return op inside {OP_READ, OP_FAST_READ, OP_DUAL_IO_READ, OP_DUAL_OUT_READ, OP_QUAD_IO_READ,
                        OP_QUAD_OUT_READ, OP_STATUS_READ, OP_FUNC_READ, OP_RESUME_A, OP_RESUME_B,
                        OP_WAKE, OP_UNIQUE_ID, OP_JEDEC_ID, OP_MFR_ID, OP_PARAM_READ,
                        OP_RESET_ARM, OP_RESET, OP_INFO_ROW_READ};
   endfunction

   // two-stage sync, then stage three for history
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sel_sync <= 3'h7;
         sclk_sync <= 3'h0;
         sdi_sync <= 3'h0;
      end else begin
         sel_sync <= {sel_sync[1:0], sel_n};
         sclk_sync <= {sclk_sync[1:0], sclk};
         sdi_sync <= {sdi_sync[1:0], sdi};
      end
   end
   assign sel_q = sel_sync[1];
   assign sclk_q = sclk_sync[1];
   assign sdi_q = sdi_sync[1];
   assign sclk_d = sclk_sync[2];
   wire sclk_rise = sclk_q & ~sclk_d & ~sel_q;
   wire sel_rise = sel_q & ~sel_sync[2];
   wire byte_done = sclk_rise & (bit_cnt == 4'h7);
   wire [7:0] next_byte = {shift[6:0], sdi_q};

   wire busy = (state == S_BUSY);
   wire suspended = (state == S_SUSPENDED);
   wire write_enable_latch = status[ST_WEL];
   wire chip_op = (opcode == OP_CHIP_ERASE_A) || (opcode == OP_CHIP_ERASE_B);
   wire prog_op = opcode inside {OP_PAGE_PROG, OP_PAGE_PROG_QA, OP_PAGE_PROG_QB};
   wire sect_op = (opcode == OP_SECTOR_ERASE_A) || (opcode == OP_SECTOR_ERASE_B);
   wire blk_op = (opcode == OP_BLOCK_ERASE_32) || (opcode == OP_BLOCK_ERASE_64);
   wire susp_op = (opcode == OP_SUSPEND_A) || (opcode == OP_SUSPEND_B);
   wire res_op = (opcode == OP_RESUME_A) || (opcode == OP_RESUME_B);
   // opcode accepted by current state
   wire allowed = (state == S_IDLE) ? 1'b1 :
                  busy ? (opcode == OP_STATUS_READ) || (susp_op && active_op inside {FWC_OP_PROG, FWC_OP_SECTOR,
                         FWC_OP_BLOCK} && gap_cnt == 32'h0) :
                  suspended ? is_susp_ok(opcode) :
                  (state == S_SLEEP) ? (opcode == OP_WAKE) : 1'b0;
   wire frame_end = sel_rise & op_valid & allowed;
   // chip erase only when select rose right after the opcode byte
   wire ce_go = frame_end & chip_op & ~op_extra & write_enable_latch;
   wire arr_go = frame_end & (prog_op | sect_op | blk_op) & data_phase & write_enable_latch;
   wire sr_go = frame_end & (opcode == OP_STATUS_WRITE) & data_phase & write_enable_latch & ~op_extra;
   wire fr_go = frame_end & (opcode == OP_FUNC_WRITE) & data_phase & write_enable_latch & ~op_extra;
   wire susp_go = frame_end & susp_op & ~op_extra & busy;
   wire res_go = frame_end & res_op & ~op_extra & suspended;
   wire sleep_go = frame_end & (opcode == OP_DEEP_SLEEP) & ~op_extra;
   wire wake_go = frame_end & (opcode == OP_WAKE) & (state == S_SLEEP);
   wire op_finish = busy & (op_left == 32'h1);
   fwc_op_t next_op;
   assign next_op = prog_op ? FWC_OP_PROG : sect_op ? FWC_OP_SECTOR : blk_op ? FWC_OP_BLOCK : FWC_OP_NONE;
   wire [31:0] op_len = prog_op ? 32'(PROG_CYC) : sect_op ? 32'(SECTOR_CYC) : 32'(BLOCK_CYC);

   // serial shifter and opcode capture
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         shift <= 8'h00;
         bit_cnt <= 4'h0;
         opcode <= 8'h00;
         op_valid <= 1'b0;
         data_phase <= 1'b0;
         op_extra <= 1'b0;
         wdata <= 8'h00;
      end else if (sel_q) begin
         bit_cnt <= 4'h0;
         op_valid <= 1'b0;
         data_phase <= 1'b0;
         op_extra <= 1'b0;
      end else if (sclk_rise) begin
         shift <= next_byte;
         bit_cnt <= (bit_cnt == 4'h7) ? 4'h0 : bit_cnt + 4'h1;
         if (op_valid && bit_cnt == 4'h0)
            op_extra <= data_phase | ~(prog_op | sect_op | blk_op | opcode inside {OP_STATUS_WRITE, OP_FUNC_WRITE});
         if (byte_done && !op_valid) begin
            opcode <= next_byte;
            op_valid <= 1'b1;
         end else if (byte_done) begin
            data_phase <= 1'b1;
            if (!data_phase)
               wdata <= next_byte;
         end
      end
   end

   // read responses for status and function register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= sclk_rise & (bit_cnt == 4'h0) & op_valid & ~data_phase & allowed &
                     (opcode inside {OP_STATUS_READ, OP_FUNC_READ}) & (state != S_SUSP_WAIT);
         if (opcode == OP_STATUS_READ)
            rd_data <= status;
         else
            rd_data <= func;
      end
   end

   // status register: busy bit, write latch, protect bits
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         status <= STATUS_RESET;
      end else begin
         status[ST_WIP] <= (state == S_BUSY) | (state == S_SUSP_WAIT);
         if (op_finish || susp_go)
            status[ST_WEL] <= 1'b0;
         else if (frame_end && opcode == OP_WEL_SET && state == S_IDLE)
            status[ST_WEL] <= 1'b1;
         else if ((frame_end && opcode == OP_WEL_CLEAR && state == S_IDLE) || ce_go || arr_go || sr_go || fr_go)
            status[ST_WEL] <= (ce_go | arr_go | sr_go | fr_go) & ~(frame_end & opcode == OP_WEL_CLEAR);
         if (sr_go && state == S_IDLE)
            status[ST_STATUS_WRITE_DISABLE:ST_BP_LO] <= wdata[ST_STATUS_WRITE_DISABLE:ST_BP_LO];
      end
   end

   // function register: lock bit sticks, suspend flags
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         func <= FUNC_RESET;
      end else begin
         if (fr_go && state == S_IDLE)
            func[FR_INFO_ROW_LOCK] <= func[FR_INFO_ROW_LOCK] | wdata[FR_INFO_ROW_LOCK];
         if (susp_go)
            func[active_op == FWC_OP_PROG ? FR_PROGRAM_SUSPENDED_FLAG : FR_ERASE_SUSPENDED_FLAG] <= 1'b1;
         else if (res_go)
            func[active_op == FWC_OP_PROG ? FR_PROGRAM_SUSPENDED_FLAG : FR_ERASE_SUSPENDED_FLAG] <= 1'b0;
      end
   end

   // operation sequencer
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= S_IDLE;
         active_op <= FWC_OP_NONE;
         op_left <= 32'h0;
         timer <= 32'h0;
         gap_cnt <= 32'h0;
      end else begin
         if (gap_cnt != 32'h0)
            gap_cnt <= gap_cnt - 32'h1;
         unique case (state)
            S_IDLE: begin
               if (ce_go && state == S_IDLE) begin
                  state <= S_BUSY;
                  active_op <= FWC_OP_CHIP;
                  op_left <= 32'(CHIP_CYC);
               end else if (arr_go) begin
                  state <= S_BUSY;
                  active_op <= next_op;
                  op_left <= op_len;
               end else if (sr_go || fr_go) begin
                  state <= S_BUSY;
                  active_op <= FWC_OP_REG;
                  op_left <= 32'(REGW_CYC);
               end else if (sleep_go) begin
                  state <= S_SLEEP_WAIT;
                  timer <= 32'(SLEEP_CYC);
               end
            end
            S_BUSY: begin
               if (susp_go) begin
                  state <= S_SUSP_WAIT;
                  timer <= 32'(SUSPEND_CYC);
               end else if (op_finish) begin
                  state <= S_IDLE;
                  active_op <= FWC_OP_NONE;
               end else begin
                  op_left <= op_left - 32'h1;
               end
            end
            S_SUSP_WAIT: begin
               timer <= timer - 32'h1;
               if (timer == 32'h1)
                  state <= S_SUSPENDED;
            end
            S_SUSPENDED: begin
               if (res_go) begin
                  state <= S_BUSY;
                  gap_cnt <= 32'(RESUME_GAP);
               end
            end
            S_SLEEP_WAIT: begin
               timer <= timer - 32'h1;
               if (timer == 32'h1)
                  state <= S_SLEEP;
            end
            S_SLEEP: begin
               if (wake_go) begin
                  state <= S_WAKE_WAIT;
                  timer <= 32'(WAKE_CYC);
               end
            end
            S_WAKE_WAIT: begin
               timer <= timer - 32'h1;
               if (timer == 32'h1)
                  state <= S_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         array_req <= '0;
      else begin
         array_req.start <= ce_go | arr_go;
         array_req.chip_erase <= ce_go;
         array_req.prog <= arr_go & prog_op;
         array_req.sector <= arr_go & sect_op;
         array_req.block <= arr_go & blk_op;
      end
   end

   assign regs.status = status;
   assign regs.func = func;
   assign sleeping = (state == S_SLEEP);
   assign accept_ready = (state == S_IDLE) | suspended;

   a_wel_set_cmd: assert property (@(posedge clk) disable iff (!reset_n)
      (frame_end && opcode == OP_WEL_SET && state == S_IDLE && !op_finish) |=> status[ST_WEL])
      else $error("latch not set");
   a_wel_clear_cmd: assert property (@(posedge clk) disable iff (!reset_n)
      (frame_end && opcode == OP_WEL_CLEAR && state == S_IDLE) |=> !status[ST_WEL])
      else $error("latch not cleared");
   a_chip_needs_wel: assert property (@(posedge clk) disable iff (!reset_n)
      array_req.chip_erase |-> $past(status[ST_WEL]))
      else $error("chip erase without latch");
   a_finish_clears_wel: assert property (@(posedge clk) disable iff (!reset_n)
      op_finish |=> !status[ST_WEL] && state == S_IDLE)
      else $error("latch kept after write");
   a_suspend_flag_set: assert property (@(posedge clk) disable iff (!reset_n)
      susp_go |=> (func[FR_PROGRAM_SUSPENDED_FLAG] | func[FR_ERASE_SUSPENDED_FLAG]) && !status[ST_WEL])
      else $error("suspend flag missing");
   a_resume_clears_flag: assert property (@(posedge clk) disable iff (!reset_n)
      res_go |=> !func[FR_PROGRAM_SUSPENDED_FLAG] && !func[FR_ERASE_SUSPENDED_FLAG] && state == S_BUSY)
      else $error("suspend flag stuck");
   a_sleep_filter: assert property (@(posedge clk) disable iff (!reset_n)
      (state == S_SLEEP) |=> $stable(status[7:1]) && $stable(func))
      else $error("sleep state changed registers");
   a_busy_bit: assert property (@(posedge clk) disable iff (!reset_n)
      (state == S_BUSY) |=> status[ST_WIP])
      else $error("busy bit low while busy");
   a_chip_select_rise: assert property (@(posedge clk) disable iff (!reset_n)
      array_req.chip_erase |-> $past(sel_rise) && !$past(op_extra))
      else $error("chip erase without clean select rise");
endmodule

//--- shared/fwc_pkg.sv
// constants and types for the flash command interpreter
// assumes a host spi controller drives select, serial clock and data in
package fwc_pkg;
   localparam logic [7:0] OP_CHIP_ERASE_A = 8'hC7;
   localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
   localparam logic [7:0] OP_WEL_SET = 8'h06;
   localparam logic [7:0] OP_WEL_CLEAR = 8'h04;
   localparam logic [7:0] OP_STATUS_READ = 8'h05;
   localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
   localparam logic [7:0] OP_FUNC_READ = 8'h48;
   localparam logic [7:0] OP_FUNC_WRITE = 8'h42;
   localparam logic [7:0] OP_SUSPEND_A = 8'h75;
   localparam logic [7:0] OP_SUSPEND_B = 8'hB0;
   localparam logic [7:0] OP_RESUME_A = 8'h7A;
   localparam logic [7:0] OP_RESUME_B = 8'h30;
   localparam logic [7:0] OP_DEEP_SLEEP = 8'hB9;
   localparam logic [7:0] OP_WAKE = 8'hAB;
   localparam logic [7:0] OP_PAGE_PROG = 8'h02;
   localparam logic [7:0] OP_PAGE_PROG_QA = 8'h32;
   localparam logic [7:0] OP_PAGE_PROG_QB = 8'h38;
   localparam logic [7:0] OP_SECTOR_ERASE_A = 8'hD7;
   localparam logic [7:0] OP_SECTOR_ERASE_B = 8'h20;
   localparam logic [7:0] OP_BLOCK_ERASE_32 = 8'h52;
   localparam logic [7:0] OP_BLOCK_ERASE_64 = 8'hD8;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_FAST_READ = 8'h0B;
   localparam logic [7:0] OP_DUAL_IO_READ = 8'hBB;
   localparam logic [7:0] OP_DUAL_OUT_READ = 8'h3B;
   localparam logic [7:0] OP_QUAD_IO_READ = 8'hEB;
   localparam logic [7:0] OP_QUAD_OUT_READ = 8'h6B;
   localparam logic [7:0] OP_UNIQUE_ID = 8'h4B;
   localparam logic [7:0] OP_JEDEC_ID = 8'h9F;
   localparam logic [7:0] OP_MFR_ID = 8'h90;
   localparam logic [7:0] OP_PARAM_READ = 8'h5A;
   localparam logic [7:0] OP_RESET_ARM = 8'h66;
   localparam logic [7:0] OP_RESET = 8'h99;
   localparam logic [7:0] OP_INFO_ROW_READ = 8'h68;
   // status register fields
   localparam int ST_WIP = 0;
   localparam int ST_WEL = 1;
   localparam int ST_BP_LO = 2;
   localparam int ST_QE = 6;
   localparam int ST_STATUS_WRITE_DISABLE = 7;
   localparam logic [7:0] ST_WRITE_MASK = 8'hFC;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   // function register fields
   localparam int FR_INFO_ROW_LOCK = 0;
   localparam int FR_PROGRAM_SUSPENDED_FLAG = 2;
   localparam int FR_ERASE_SUSPENDED_FLAG = 3;
   localparam logic [7:0] FUNC_RESET = 8'h00;
   // timing
   localparam int CLK_MHZ = 125;
   localparam int SUSPEND_LATENCY_US = 100;
   localparam int SUSPEND_LATENCY_CYC = SUSPEND_LATENCY_US * CLK_MHZ;
   localparam int RESUME_GAP_US = 1500;
   localparam int RESUME_GAP_CYC = RESUME_GAP_US * CLK_MHZ;
   localparam int SLEEP_ENTRY_DELAY_US = 3;
   localparam int SLEEP_ENTRY_DELAY_CYC = SLEEP_ENTRY_DELAY_US * CLK_MHZ;
   localparam int WAKE_DELAY_US = 5;
   localparam int WAKE_DELAY_CYC = WAKE_DELAY_US * CLK_MHZ;
   localparam int PAGE_PROGRAM_TIME_US = 800;
   localparam int PAGE_PROGRAM_CYC = PAGE_PROGRAM_TIME_US * CLK_MHZ;
   localparam int SECTOR_ERASE_TIME_US = 100000;
   localparam int SECTOR_ERASE_CYC = SECTOR_ERASE_TIME_US * CLK_MHZ;
   localparam int BLOCK_ERASE_TIME_US = 500000;
   localparam int BLOCK_ERASE_CYC = BLOCK_ERASE_TIME_US * CLK_MHZ;
   localparam int CHIP_ERASE_TIME_US = 10000000;
   localparam longint CHIP_ERASE_CYC = longint'(CHIP_ERASE_TIME_US) * CLK_MHZ;
   localparam int REG_WRITE_TIME_US = 2000;
   localparam int REG_WRITE_CYC = REG_WRITE_TIME_US * CLK_MHZ;

   typedef enum logic [2:0] {
      FWC_OP_NONE, FWC_OP_PROG, FWC_OP_SECTOR, FWC_OP_BLOCK, FWC_OP_CHIP, FWC_OP_REG
   } fwc_op_t;

   typedef struct packed {
      logic start;
      logic chip_erase;
      logic prog;
      logic sector;
      logic block;
   } fwc_array_req_t;

   typedef struct packed {
      logic [7:0] status;
      logic [7:0] func;
   } fwc_regs_t;
endpackage

//--- testbench/fwc_flash_ctrl_bench.sv
// bench for the flash command interpreter: frames through the host model
// assumes shortened operation times set by the parameters below
`timescale 1ns/100ps
module fwc_flash_ctrl_bench import fwc_pkg::*;;
   localparam int SUS = 20, GAP = 300, SLP = 10, WAK = 10, PRG = 2000, SEC = 3000, CHP = 1000, RGW = 300;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic sel_n, sclk, sdi, rd_valid, sleeping, accept_ready;
   logic [7:0] rd_data;
   fwc_regs_t regs;
   fwc_array_req_t array_req;
   int failures = 0;
   int n_compared = 0;
   logic [7:0] n_chip = 8'h00;
   logic [7:0] n_sect = 8'h00;
   logic [7:0] n_prog = 8'h00;
   logic [7:0] n_blk = 8'h00;
   always #4 clk = ~clk;
   fwc_flash_ctrl #(.SUSPEND_CYC(SUS), .RESUME_GAP(GAP), .SLEEP_CYC(SLP), .WAKE_CYC(WAK), .PROG_CYC(PRG),
      .SECTOR_CYC(SEC), .BLOCK_CYC(SEC), .CHIP_CYC(CHP), .REGW_CYC(RGW)) fwc_flash_ctrl_inst (.clk(clk),
      .reset_n(reset_n), .sel_n(sel_n), .sclk(sclk), .sdi(sdi), .rd_data(rd_data), .rd_valid(rd_valid),
      .regs(regs), .array_req(array_req), .sleeping(sleeping), .accept_ready(accept_ready));
   fwc_host_model fwc_host_model_inst (.clk(clk), .sel_n(sel_n), .sclk(sclk), .sdi(sdi), .rd_data(rd_data),
      .rd_valid(rd_valid));
   always @(posedge clk) begin
      if (array_req.start === 1'b1 && array_req.chip_erase === 1'b1) n_chip++;
      if (array_req.start === 1'b1 && array_req.sector === 1'b1) n_sect++;
      if (array_req.start === 1'b1 && array_req.prog === 1'b1) n_prog++;
      if (array_req.start === 1'b1 && array_req.block === 1'b1) n_blk++;
   end
   task automatic check8(input logic [7:0] a, input logic [7:0] e);
      n_compared++;
      if (a !== e) begin
         failures++;
         $display("Error at %0t ns: got 0x%0h, expected 0x%0h", $time, a, e);
      end
   endtask
   task automatic check1(input logic a, input logic e);
      check8({7'h00, a}, {7'h00, e});
   endtask
   // bounded wait on busy (0), ready (1) or sleeping (2)
   task automatic wait_for(input int what, input logic val, input int lim);
      logic cur;
      for (int i = 0; i <= lim; i++) begin
         @(posedge clk);
         cur = (what == 0) ? regs.status[ST_WIP] : (what == 1) ? accept_ready : sleeping;
         if (cur === val) break;
      end
      check1(cur, val);
   endtask
   task automatic summarize();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      #(8 * 40000);
      failures++;
      summarize();
   end
   initial begin
      logic [7:0] v;
      logic ok;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      check8(regs.status, STATUS_RESET);
      check8(regs.func, FUNC_RESET);
      fwc_host_model_inst.cmd(OP_WEL_SET);
      check1(regs.status[ST_WEL], 1'b1);
      fwc_host_model_inst.cmd(OP_WEL_CLEAR);
      check1(regs.status[ST_WEL], 1'b0);
      fwc_host_model_inst.cmd(OP_CHIP_ERASE_A);
      check8(n_chip, 8'h00);
      fwc_host_model_inst.cmd(OP_WEL_SET);
      fwc_host_model_inst.cmd2(OP_CHIP_ERASE_A, 8'h00);
      check8(n_chip, 8'h00);
      check1(regs.status[ST_WEL], 1'b1);
      fwc_host_model_inst.cmd(OP_CHIP_ERASE_B);
      check8(n_chip, 8'h01);
      check1(regs.status[ST_WIP], 1'b1);
      fwc_host_model_inst.cmd(OP_WEL_CLEAR);
      fwc_host_model_inst.rd(OP_STATUS_READ, v, ok);
      check8(v, 8'h03);
      wait_for(0, 1'b0, CHP);
      check8(regs.status, 8'h00);
      fwc_host_model_inst.cmd2(OP_STATUS_WRITE, 8'h7C);
      check8(regs.status, 8'h00);
      fwc_host_model_inst.cmd(OP_WEL_SET);
      fwc_host_model_inst.cmd2(OP_STATUS_WRITE, 8'h7C);
      wait_for(0, 1'b0, RGW);
      check8(regs.status, 8'h7C);
      fwc_host_model_inst.cmd(OP_WEL_SET);
      fwc_host_model_inst.cmd2(OP_STATUS_WRITE, 8'h00);
      wait_for(0, 1'b0, RGW);
      fwc_host_model_inst.cmd(OP_WEL_SET);
      fwc_host_model_inst.cmd2(OP_FUNC_WRITE, 8'h01);
      wait_for(0, 1'b0, RGW);
      fwc_host_model_inst.rd(OP_FUNC_READ, v, ok);
      check8(v, 8'h01);
      check8(regs.status, 8'h00);
      fwc_host_model_inst.cmd(OP_WEL_SET);
      fwc_host_model_inst.cmd2(OP_SECTOR_ERASE_A, 8'h00);
      check8(n_sect, 8'h01);
      fwc_host_model_inst.cmd(OP_SUSPEND_A);
      check1(regs.func[FR_ERASE_SUSPENDED_FLAG], 1'b1);
      check1(regs.status[ST_WEL], 1'b0);
      wait_for(1, 1'b1, SUS);
      fwc_host_model_inst.cmd(OP_WEL_SET);
      check1(regs.status[ST_WEL], 1'b0);
      fwc_host_model_inst.rd(OP_FUNC_READ, v, ok);
      check8(v, 8'h09);
      fwc_host_model_inst.cmd(OP_RESUME_B);
      check1(regs.func[FR_ERASE_SUSPENDED_FLAG], 1'b0);
      check1(regs.status[ST_WIP], 1'b1);
      wait_for(0, 1'b0, SEC);
      fwc_host_model_inst.cmd(OP_WEL_SET);
      fwc_host_model_inst.cmd2(OP_PAGE_PROG, 8'h00);
      check8(n_prog, 8'h01);
      fwc_host_model_inst.cmd(OP_SUSPEND_B);
      check1(regs.func[FR_PROGRAM_SUSPENDED_FLAG], 1'b1);
      wait_for(1, 1'b1, SUS);
      fwc_host_model_inst.cmd(OP_RESUME_A);
      check1(regs.func[FR_PROGRAM_SUSPENDED_FLAG], 1'b0);
      wait_for(0, 1'b0, PRG);
      fwc_host_model_inst.cmd(OP_WEL_SET);
      fwc_host_model_inst.cmd2(OP_BLOCK_ERASE_64, 8'h00);
      check8(n_blk, 8'h01);
      check1(regs.status[ST_WIP], 1'b1);
      wait_for(0, 1'b0, SEC);
      check1(regs.status[ST_WEL], 1'b0);
      fwc_host_model_inst.cmd2(OP_DEEP_SLEEP, 8'h00);
      check1(sleeping, 1'b0);
      fwc_host_model_inst.cmd(OP_DEEP_SLEEP);
      wait_for(2, 1'b1, SLP);
      fwc_host_model_inst.rd(OP_STATUS_READ, v, ok);
      check1(ok, 1'b0);
      fwc_host_model_inst.cmd(OP_WEL_SET);
      check1(regs.status[ST_WEL], 1'b0);
      fwc_host_model_inst.cmd(OP_WAKE);
      wait_for(2, 1'b0, WAK);
      fwc_host_model_inst.cmd(OP_WEL_SET);
      check1(regs.status[ST_WEL], 1'b1);
      summarize();
   end
endmodule

//--- testbench/fwc_host_model.sv
// host spi controller model: mode 0 frames on select, serial clock, data in
// assumes clk is the device clock; all pins change at its rising edge
`timescale 1ns/100ps
module fwc_host_model import fwc_pkg::*; (
   input wire logic clk,
   output logic sel_n,
   output logic sclk,
   output logic sdi,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid
);
   logic [7:0] got;
   logic got_ok;
   initial begin
      sel_n = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
   end
   // half of a 160 ns serial period, catching read data
   task automatic half();
      repeat (10) begin
         @(posedge clk);
         if (rd_valid === 1'b1) begin
            got = rd_data;
            got_ok = 1'b1;
         end
      end
   endtask
   task automatic shift(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         sdi <= b[i];
         half();
         sclk <= 1'b1;
         half();
         sclk <= 1'b0;
      end
   endtask
   task automatic open_f();
      @(posedge clk);
      sel_n <= 1'b0;
      got_ok = 1'b0;
      half();
   endtask
   // select rises right after the last clock; line flips once released
   task automatic close_f();
      half();
      sel_n <= 1'b1;
      sdi <= ~sdi;
      repeat (16) @(posedge clk);
   endtask
   task automatic cmd(input logic [7:0] op);
      open_f();
      shift(op);
      close_f();
   endtask
   task automatic cmd2(input logic [7:0] op, input logic [7:0] d);
      open_f();
      shift(op);
      shift(d);
      close_f();
   endtask
   task automatic rd(input logic [7:0] op, output logic [7:0] v, output logic ok);
      open_f();
      shift(op);
      shift(8'hFF);
      close_f();
      v = got;
      ok = got_ok;
   endtask
endmodule
